// File: rtl/mbac_top.sv
// Purpose: Checks every CPU memory and SFR access against the mode policy
// Assumes: Memory and SFR read data return in the cycle the strobe is high
// Notes: Fixed two-cycle answer; a request may be made every cycle

`timescale 1ns/1ps
module mbac_top (
	input wire logic clock,
	input wire logic reset,
	input wire logic cpu_req,
	input wire mbac_pkg::mbac_op_e cpu_op,
	input wire logic cpu_sfr,
	input wire logic [mbac_pkg::VA_W-1:0] cpu_addr,
	input wire logic [mbac_pkg::VA_W-1:0] cpu_pc,
	input wire logic [mbac_pkg::DW-1:0] cpu_wdata,
	input wire logic [7:0] program_status_high_word,
	input wire logic boot_bit,
	input wire logic test_bit,
	input wire logic [mbac_pkg::HWR_W-1:0] firewall_hw_rights,
	input wire logic seg_wr,
	input wire logic [mbac_pkg::SEG_IW-1:0] seg_wr_index,
	input wire mbac_pkg::mbac_seg_s seg_wr_entry,
	input wire logic [mbac_pkg::DW-1:0] mem_rdata,
	input wire logic [mbac_pkg::DW-1:0] sfr_rdata,
	output logic mem_req,
	output logic mem_we,
	output logic [mbac_pkg::PA_W-1:0] mem_addr,
	output logic [mbac_pkg::DW-1:0] mem_wdata,
	output logic sfr_rd_en,
	output logic sfr_wr_en,
	output logic [mbac_pkg::SFR_AW-1:0] sfr_addr,
	output logic [mbac_pkg::DW-1:0] sfr_wdata,
	output logic cpu_done,
	output logic [mbac_pkg::DW-1:0] cpu_rdata,
	output logic cpu_violation,
	output mbac_pkg::mbac_mode_e cpu_mode
);
	// All state of the checker
	typedef struct packed {
		logic mem_req; // Granted memory strobe
		logic mem_we; // Write qualifier
		logic [mbac_pkg::PA_W-1:0] mem_addr; // Physical address
		logic [mbac_pkg::DW-1:0] wdata; // Write data to memory or SFR
		logic sfr_rd; // Granted SFR read strobe
		logic sfr_wr; // Granted SFR write strobe
		logic [mbac_pkg::SFR_AW-1:0] sfr_addr; // SFR address
		logic p_valid; // Request in flight
		logic p_rd; // It returns data
		logic p_sfr; // Its data comes from the SFR side
		logic p_ok; // It was granted
		logic done; // Answer strobe
		logic [mbac_pkg::DW-1:0] rdata; // Answer data
		logic viol; // Answer was a denial
	} mbac_top_s;
	mbac_top_s r_reg;
	mbac_top_s r_next;

	mbac_pkg::mbac_mode_e mode; // Current mode, registered
	logic [mbac_pkg::PA_W-1:0] pa; // Address after translation
	mbac_pkg::mbac_region_e rg; // Region of that address
	mbac_pkg::mbac_sfrgrp_e grp; // Group of the SFR address
	logic allow; // Verdict for the current request
	mbac_seg_if sif ();

	// Mode tracker
	mbac_mode_dec u_mode (
		.clock(clock),
		.reset(reset),
		.program_status_high_word(program_status_high_word),
		.boot_bit(boot_bit),
		.test_bit(test_bit),
		.mode(mode)
	);

	// Segment table
	mbac_seg_table #(
		.SEG_N(mbac_pkg::SEG_N)
	) u_seg (
		.clock(clock),
		.reset(reset),
		.s(sif.tab)
	);

	// Right of a segment for one operation
	function automatic logic op_right(input mbac_pkg::mbac_op_e op, input logic [mbac_pkg::RT_W-1:0] rt);
		case (op)
			mbac_pkg::OP_READ: return rt[mbac_pkg::RT_R];
			mbac_pkg::OP_WRITE: return rt[mbac_pkg::RT_WR];
			mbac_pkg::OP_EXEC: return rt[mbac_pkg::RT_X];
			default: return 1'b0;
		endcase
	endfunction

	// Application memories: ROM never written, RAM never executed
	function automatic logic app_ok(input mbac_pkg::mbac_op_e op, input mbac_pkg::mbac_region_e r);
		return (r == mbac_pkg::RG_APP_ROM && op != mbac_pkg::OP_WRITE) || r == mbac_pkg::RG_APP_EE ||
			(r == mbac_pkg::RG_APP_RAM && op != mbac_pkg::OP_EXEC);
	endfunction

	// Memory verdict from mode, region and segment rights only
	function automatic logic mem_allow(input mbac_pkg::mbac_mode_e m, input mbac_pkg::mbac_op_e op,
		input mbac_pkg::mbac_region_e r, input logic hit, input logic [mbac_pkg::RT_W-1:0] rt);
		logic rom_ok;
		logic ram_ok;
		logic a;
		rom_ok = op != mbac_pkg::OP_WRITE;
		ram_ok = op != mbac_pkg::OP_EXEC;
		case (m)
			// Boot and contactless-OS share one partition set
			mbac_pkg::MODE_BOOT, mbac_pkg::MODE_CLOS: begin
				a = (r == mbac_pkg::RG_TEST_ROM && rom_ok) || r == mbac_pkg::RG_CL_EE ||
					(r == mbac_pkg::RG_CL_RAM && ram_ok);
			end
			// Test reaches every partition
			mbac_pkg::MODE_TEST: begin
				a = ((r == mbac_pkg::RG_TEST_ROM || r == mbac_pkg::RG_APP_ROM) && rom_ok) ||
					r == mbac_pkg::RG_CL_EE || r == mbac_pkg::RG_APP_EE ||
					((r == mbac_pkg::RG_CL_RAM || r == mbac_pkg::RG_APP_RAM) && ram_ok);
			end
			// System owns the application side
			mbac_pkg::MODE_SYS: begin
				a = app_ok(op, r);
			end
			// User gets only what a segment grants
			mbac_pkg::MODE_USER: begin
				a = hit && op_right(op, rt) && app_ok(op, r);
			end
			default: begin
				a = 1'b0;
			end
		endcase
		return a;
	endfunction

	// SFR verdict, decided per register group and mode
	function automatic logic sfr_allow(input mbac_pkg::mbac_mode_e m, input logic wr,
		input mbac_pkg::mbac_sfrgrp_e g, input logic pc_hit, input logic [mbac_pkg::HWR_W-1:0] seg_hw,
		input logic [mbac_pkg::HWR_W-1:0] fw_hw);
		logic priv;
		logic a;
		priv = m == mbac_pkg::MODE_BOOT || m == mbac_pkg::MODE_TEST || m == mbac_pkg::MODE_SYS;
		case (g)
			// Accumulator, stack and pointers belong to everyone
			mbac_pkg::SG_CPU: a = 1'b1;
			// Segmentation setup hidden from user code
			mbac_pkg::SG_MMU: a = priv;
			// System management readable by all, written by privileged code
			mbac_pkg::SG_SYS: a = !wr || priv;
			// Firewall setup must not be touched by the code it fences
			mbac_pkg::SG_FW: a = priv;
			// Contactless-OS private registers
			mbac_pkg::SG_CLOS: a = m == mbac_pkg::MODE_BOOT || m == mbac_pkg::MODE_TEST || m == mbac_pkg::MODE_CLOS;
			// Test registers only in test mode
			mbac_pkg::SG_TEST: a = m == mbac_pkg::MODE_TEST;
			// Hardware blocks: user via segment, contactless-OS via firewall
			mbac_pkg::SG_HW: begin
				if (m == mbac_pkg::MODE_USER) begin
					a = pc_hit && seg_hw[wr ? mbac_pkg::HW_WB : mbac_pkg::HW_RD];
				end else if (m == mbac_pkg::MODE_CLOS) begin
					a = fw_hw[wr ? mbac_pkg::HW_WB : mbac_pkg::HW_RD];
				end else begin
					a = priv;
				end
			end
			default: a = 1'b0;
		endcase
		return a;
	endfunction

	// Translation, lookup and verdict for the request on the bus now
	always_comb begin
		sif.va = cpu_addr;
		sif.pc = cpu_pc;
		// Table loads only from system or test code, so user code cannot widen its own rights
		sif.wr_en = seg_wr && (mode == mbac_pkg::MODE_SYS || mode == mbac_pkg::MODE_TEST);
		sif.wr_idx = seg_wr_index;
		sif.wr_ent = seg_wr_entry;
		// Only user code is relocated; privileged modes see physical space directly
		pa = (mode == mbac_pkg::MODE_USER) ? sif.pa : cpu_addr;
		rg = mbac_pkg::region_of(pa);
		grp = mbac_pkg::sfr_group(cpu_addr[mbac_pkg::SFR_AW-1:0]);
		if (cpu_sfr) begin
			allow = sfr_allow(mode, cpu_op == mbac_pkg::OP_WRITE, grp, sif.pc_hit, sif.pc_hw,
				firewall_hw_rights);
		end else begin
			allow = mem_allow(mode, cpu_op, rg, sif.hit, sif.rights);
		end
	end

	// Two stages: strobe the target if granted, then answer the CPU
	always_comb begin
		r_next = r_reg;
		// Strobes are single-cycle
		r_next.mem_req = 1'b0;
		r_next.mem_we = 1'b0;
		r_next.sfr_rd = 1'b0;
		r_next.sfr_wr = 1'b0;
		// Stage one: verdict is formed before any strobe goes out
		r_next.p_valid = cpu_req;
		r_next.p_rd = cpu_op != mbac_pkg::OP_WRITE;
		r_next.p_sfr = cpu_sfr;
		r_next.p_ok = allow;
		if (cpu_req && allow) begin
			r_next.wdata = cpu_wdata;
			if (cpu_sfr) begin
				r_next.sfr_rd = cpu_op != mbac_pkg::OP_WRITE;
				r_next.sfr_wr = cpu_op == mbac_pkg::OP_WRITE;
				r_next.sfr_addr = cpu_addr[mbac_pkg::SFR_AW-1:0];
			end else begin
				r_next.mem_req = 1'b1;
				r_next.mem_we = cpu_op == mbac_pkg::OP_WRITE;
				r_next.mem_addr = pa;
			end
		end
		// Denied writes simply never strobe, so the target keeps its value
		// Stage two: answer with data, or zero and a flag on denial
		r_next.done = r_reg.p_valid;
		r_next.viol = r_reg.p_valid && !r_reg.p_ok;
		if (r_reg.p_valid && r_reg.p_rd && r_reg.p_ok) begin
			r_next.rdata = r_reg.p_sfr ? sfr_rdata : mem_rdata;
		end else begin
			r_next.rdata = '0;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (reset) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state
	assign mem_req = r_reg.mem_req;
	assign mem_we = r_reg.mem_we;
	assign mem_addr = r_reg.mem_addr;
	assign mem_wdata = r_reg.wdata;
	assign sfr_rd_en = r_reg.sfr_rd;
	assign sfr_wr_en = r_reg.sfr_wr;
	assign sfr_addr = r_reg.sfr_addr;
	assign sfr_wdata = r_reg.wdata;
	assign cpu_done = r_reg.done;
	assign cpu_rdata = r_reg.rdata;
	assign cpu_violation = r_reg.viol;
	assign cpu_mode = mode;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	// Denied read and the answer it must get
	sequence s_denied_rd;
		cpu_req && !allow && cpu_op != mbac_pkg::OP_WRITE;
	endsequence
	sequence s_zero_answer;
		cpu_done && cpu_violation && cpu_rdata == '0;
	endsequence
	sequence s_no_strobe;
		!mem_req && !sfr_rd_en && !sfr_wr_en;
	endsequence

	AST_DONE_TWO: assert property (cpu_req |-> ##2 cpu_done)
		else $error("answer not two cycles after request");
	AST_DENY_BLOCK: assert property (cpu_req && !allow |=> s_no_strobe ##1 cpu_violation)
		else $error("denied access reached a target");
	AST_DENY_RD_ZERO: assert property (s_denied_rd |=> ##1 s_zero_answer)
		else $error("denied read did not return zero");
	AST_GRANT_PA: assert property (cpu_req && allow && !cpu_sfr |=> mem_req && mem_addr == $past(pa))
		else $error("granted access missing or misaddressed");
	AST_TEST_ALL: assert property (cpu_req && mode == mbac_pkg::MODE_TEST && !cpu_sfr &&
		cpu_op == mbac_pkg::OP_READ && rg != mbac_pkg::RG_NONE |=> mem_req)
		else $error("test mode read was refused");
	AST_BOOT_NO_APP: assert property (cpu_req && !cpu_sfr &&
		(mode == mbac_pkg::MODE_BOOT || mode == mbac_pkg::MODE_CLOS) &&
		(rg == mbac_pkg::RG_APP_ROM || rg == mbac_pkg::RG_APP_EE || rg == mbac_pkg::RG_APP_RAM) |=> !mem_req)
		else $error("boot or contactless mode reached application memory");
	AST_SYS_NO_TEST_ROM: assert property (cpu_req && !cpu_sfr && mode == mbac_pkg::MODE_SYS &&
		rg == mbac_pkg::RG_TEST_ROM |=> !mem_req)
		else $error("system mode reached test ROM");
	AST_USER_ROM_WR: assert property (cpu_req && !cpu_sfr && mode == mbac_pkg::MODE_USER &&
		cpu_op == mbac_pkg::OP_WRITE && rg == mbac_pkg::RG_APP_ROM |=> !mem_req)
		else $error("user write reached ROM");
	AST_TEST_SFR: assert property (cpu_req && cpu_sfr && grp == mbac_pkg::SG_TEST &&
		mode != mbac_pkg::MODE_TEST |=> s_no_strobe)
		else $error("test register reached outside test mode");
	AST_USER_HW_WR: assert property (cpu_req && cpu_sfr && mode == mbac_pkg::MODE_USER &&
		grp == mbac_pkg::SG_HW && cpu_op == mbac_pkg::OP_WRITE &&
		!(sif.pc_hit && sif.pc_hw[mbac_pkg::HW_WB]) |=> !sfr_wr_en)
		else $error("user hardware register write without segment right");
endmodule

// File: rtl/mbac_pkg.sv
// Purpose: Shared types and constants for the mode based access control unit
// Assumes: 20-bit virtual and physical spaces, 8-bit data, SFRs at 8-bit addresses
// Notes: Memory map and SFR group bounds are plain defaults, easy to move

package mbac_pkg;
	// Bus widths
	localparam int VA_W = 20;
	localparam int PA_W = 20;
	localparam int DW = 8;
	localparam int SFR_AW = 8;
	// Segment table size and index width
	localparam int SEG_N = 64;
	localparam int SEG_IW = 6;
	// Rights vector layout
	localparam int RT_W = 3;
	localparam int RT_R = 0;
	localparam int RT_WR = 1;
	localparam int RT_X = 2;
	localparam int HWR_W = 2;
	localparam int HW_RD = 0;
	localparam int HW_WB = 1;
	// Bits of the program status high word that pick the mode
	localparam int PSW_SYS_BIT = 7;
	localparam int PSW_CLOS_BIT = 6;

	// CPU modes; boot is where the chip wakes up
	typedef enum logic [2:0] {MODE_BOOT, MODE_TEST, MODE_CLOS, MODE_SYS, MODE_USER} mbac_mode_e;
	localparam mbac_mode_e MODE_RST = MODE_BOOT;
	// Memory operations
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_EXEC} mbac_op_e;
	// Physical memory regions
	typedef enum logic [2:0] {RG_TEST_ROM, RG_APP_ROM, RG_CL_EE, RG_APP_EE, RG_CL_RAM, RG_APP_RAM,
		RG_NONE} mbac_region_e;
	// SFR groups
	typedef enum logic [2:0] {SG_CPU, SG_MMU, SG_SYS, SG_FW, SG_CLOS, SG_TEST, SG_HW} mbac_sfrgrp_e;

	// Physical map, each bound exclusive of the region below it
	localparam logic [PA_W-1:0] ROM_APP_LO = 20'h02000;
	localparam logic [PA_W-1:0] EE_CL_LO = 20'h40000;
	localparam logic [PA_W-1:0] EE_APP_LO = 20'h41000;
	localparam logic [PA_W-1:0] EE_END = 20'h54000;
	localparam logic [PA_W-1:0] RAM_CL_LO = 20'h80000;
	localparam logic [PA_W-1:0] RAM_APP_LO = 20'h80200;
	localparam logic [PA_W-1:0] RAM_END = 20'h81800;
	// SFR group lower bounds
	localparam logic [SFR_AW-1:0] SFR_MMU_LO = 8'h90;
	localparam logic [SFR_AW-1:0] SFR_SYS_LO = 8'h98;
	localparam logic [SFR_AW-1:0] SFR_FW_LO = 8'ha0;
	localparam logic [SFR_AW-1:0] SFR_CLOS_LO = 8'ha8;
	localparam logic [SFR_AW-1:0] SFR_TEST_LO = 8'hb0;
	localparam logic [SFR_AW-1:0] SFR_HW_LO = 8'hc0;

	// One segment table entry
	typedef struct packed {
		logic [RT_W-1:0] rights;
		logic [HWR_W-1:0] hw;
		logic [VA_W-1:0] first;
		logic [VA_W-1:0] last;
		logic [PA_W-1:0] reloc;
	} mbac_seg_s;

	// Region of a physical address
	function automatic mbac_region_e region_of(input logic [PA_W-1:0] a);
		if (a < ROM_APP_LO) return RG_TEST_ROM;
		if (a < EE_CL_LO) return RG_APP_ROM;
		if (a < EE_APP_LO) return RG_CL_EE;
		if (a < EE_END) return RG_APP_EE;
		if (a < RAM_CL_LO) return RG_NONE;
		if (a < RAM_APP_LO) return RG_CL_RAM;
		if (a < RAM_END) return RG_APP_RAM;
		return RG_NONE;
	endfunction

	// Group of an SFR address
	function automatic mbac_sfrgrp_e sfr_group(input logic [SFR_AW-1:0] a);
		if (a < SFR_MMU_LO) return SG_CPU;
		if (a < SFR_SYS_LO) return SG_MMU;
		if (a < SFR_FW_LO) return SG_SYS;
		if (a < SFR_CLOS_LO) return SG_FW;
		if (a < SFR_TEST_LO) return SG_CLOS;
		if (a < SFR_HW_LO) return SG_TEST;
		return SG_HW;
	endfunction
endpackage

// File: rtl/mbac_seg_if.sv
// Purpose: Lookup and load path between the checker and the segment table
// Assumes: Answers are combinational from the stored table
// Notes: Two lookups per cycle, one for data, one for the running code

`timescale 1ns/1ps
interface mbac_seg_if;
	logic [mbac_pkg::VA_W-1:0] va; // Data virtual address
	logic [mbac_pkg::VA_W-1:0] pc; // Code address of the requester
	logic hit; // Data address inside an enabled segment
	logic [mbac_pkg::RT_W-1:0] rights; // Rights of that segment
	logic [mbac_pkg::PA_W-1:0] pa; // Relocated address
	logic pc_hit; // Code address inside an enabled segment
	logic [mbac_pkg::HWR_W-1:0] pc_hw; // Hardware SFR rights of the code
	logic wr_en; // Load one entry
	logic [mbac_pkg::SEG_IW-1:0] wr_idx;
	mbac_pkg::mbac_seg_s wr_ent;
	modport req(output va, pc, wr_en, wr_idx, wr_ent, input hit, rights, pa, pc_hit, pc_hw);
	modport tab(input va, pc, wr_en, wr_idx, wr_ent, output hit, rights, pa, pc_hit, pc_hw);
endinterface

// File: rtl/mbac_mode_dec.sv
// Purpose: Holds the current CPU mode
// Assumes: Inputs come from CPU logic on the same clock
// Notes: Mode lags its sources by one cycle

`timescale 1ns/1ps
module mbac_mode_dec (
	input wire logic clock,
	input wire logic reset,
	input wire logic [7:0] program_status_high_word,
	input wire logic boot_bit,
	input wire logic test_bit,
	output mbac_pkg::mbac_mode_e mode
);
	// All state
	typedef struct packed {
		mbac_pkg::mbac_mode_e mode;
	} mbac_mode_s;
	mbac_mode_s r_reg;
	mbac_mode_s r_next;

	// Test outranks boot so a tester is never locked out
	always_comb begin
		r_next = r_reg;
		if (test_bit) begin
			r_next.mode = mbac_pkg::MODE_TEST;
		end else if (boot_bit) begin
			r_next.mode = mbac_pkg::MODE_BOOT;
		end else if (program_status_high_word[mbac_pkg::PSW_CLOS_BIT]) begin
			r_next.mode = mbac_pkg::MODE_CLOS;
		end else if (program_status_high_word[mbac_pkg::PSW_SYS_BIT]) begin
			r_next.mode = mbac_pkg::MODE_SYS;
		end else begin
			r_next.mode = mbac_pkg::MODE_USER;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (reset) begin
			r_reg <= '{mode: mbac_pkg::MODE_RST};
		end else begin
			r_reg <= r_next;
		end
	end

	assign mode = r_reg.mode;

	AST_TEST_WINS: assert property (@(posedge clock) disable iff (reset) test_bit |=> mode == mbac_pkg::MODE_TEST)
		else $error("test bit did not select test mode");
	AST_USER_DEFAULT: assert property (@(posedge clock) disable iff (reset)
		!test_bit && !boot_bit && !program_status_high_word[mbac_pkg::PSW_SYS_BIT] &&
		!program_status_high_word[mbac_pkg::PSW_CLOS_BIT] |=> mode == mbac_pkg::MODE_USER)
		else $error("plain status word did not give user mode");
endmodule

// File: rtl/mbac_seg_table.sv
// Purpose: Segment table store and address lookup
// Assumes: Loads are already vetted by the checker
// Notes: Lowest matching index wins when segments overlap

`timescale 1ns/1ps
module mbac_seg_table #(
	parameter int SEG_N = mbac_pkg::SEG_N
) (
	input wire logic clock,
	input wire logic reset,
	mbac_seg_if.tab s
);
	typedef mbac_pkg::mbac_seg_s [SEG_N-1:0] mbac_tab_t;
	// All state: the table itself
	typedef struct packed {
		mbac_tab_t ent;
	} mbac_segtab_s;
	mbac_segtab_s r_reg;
	mbac_segtab_s r_next;
	logic [mbac_pkg::SEG_IW:0] dfind; // Hit flag and index, data side
	logic [mbac_pkg::SEG_IW:0] cfind; // Hit flag and index, code side

	// First enabled segment holding the address; no rights means disabled
	function automatic logic [mbac_pkg::SEG_IW:0] find(input mbac_tab_t t, input logic [mbac_pkg::VA_W-1:0] a);
		logic [mbac_pkg::SEG_IW:0] f;
		f = '0;
		for (int i = SEG_N - 1; i >= 0; i--) begin
			if (|t[i].rights && a >= t[i].first && a <= t[i].last) begin
				f = {1'b1, (mbac_pkg::SEG_IW)'(i)};
			end
		end
		return f;
	endfunction

	// Load path and both lookups
	always_comb begin
		r_next = r_reg;
		if (s.wr_en) begin
			r_next.ent[s.wr_idx] = s.wr_ent;
		end
		dfind = find(r_reg.ent, s.va);
		cfind = find(r_reg.ent, s.pc);
		s.hit = dfind[mbac_pkg::SEG_IW];
		s.rights = s.hit ? r_reg.ent[dfind[mbac_pkg::SEG_IW-1:0]].rights : '0;
		s.pa = s.va + r_reg.ent[dfind[mbac_pkg::SEG_IW-1:0]].reloc;
		s.pc_hit = cfind[mbac_pkg::SEG_IW];
		s.pc_hw = s.pc_hit ? r_reg.ent[cfind[mbac_pkg::SEG_IW-1:0]].hw : '0;
	end

	// Empty table after reset: every segment disabled
	always_ff @(posedge clock) begin
		if (reset) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	AST_HIT_ENABLED: assert property (@(posedge clock) disable iff (reset) s.hit |-> s.rights != '0)
		else $error("lookup hit a disabled segment");
endmodule

// File: sim/mbac_mem_model.sv
// Purpose: Memory and SFR space behind the access control unit
// Assumes: Read data is combinational while the strobe is high
// Notes: Unselected data changes every cycle so a stale value never passes

`timescale 1ns/1ps
module mbac_mem_model (
	input wire logic clock,
	input wire logic mem_req,
	input wire logic [19:0] mem_addr,
	input wire logic sfr_rd_en,
	input wire logic [7:0] sfr_addr,
	output logic [7:0] mem_rdata,
	output logic [7:0] sfr_rdata
);
	// Filler for idle cycles, never a fixed level
	logic [7:0] junk_reg = 8'h00;
	always_ff @(posedge clock) begin
		junk_reg <= junk_reg + 8'h3b;
	end
	// Data is a known function of the physical address
	assign mem_rdata = mem_req ? (mem_addr[7:0] ^ 8'h5a) : junk_reg;
	assign sfr_rdata = sfr_rd_en ? (sfr_addr ^ 8'ha5) : ~junk_reg;
endmodule

// File: sim/mbac_top_test.sv
// Purpose: Self-checking bench for the access control unit
// Assumes: Fixed two-cycle answer, mode one edge after its inputs
// Notes: One request at a time; each scenario checks its own answers

`timescale 1ns/1ps
module mbac_top_test;
	logic clock = 0, reset = 1, cpu_req = 0, cpu_sfr = 0, boot_bit = 1, test_bit = 0, seg_wr = 0;
	mbac_pkg::mbac_op_e cpu_op = mbac_pkg::OP_READ;
	logic [19:0] cpu_addr = 0, cpu_pc = 0;
	logic [7:0] cpu_wdata = 8'hc3, program_status_high_word = 0, mem_rdata, sfr_rdata, mem_wdata, sfr_wdata;
	logic [7:0] sfr_addr, cpu_rdata;
	logic [1:0] firewall_hw_rights = 0;
	logic [5:0] seg_wr_index = 0;
	mbac_pkg::mbac_seg_s seg_wr_entry = '0;
	logic mem_req, mem_we, sfr_rd_en, sfr_wr_en, cpu_done, cpu_violation;
	logic [19:0] mem_addr;
	mbac_pkg::mbac_mode_e cpu_mode;
	int bad_count = 0, samples_checked = 0;
	mbac_top dut_u (.clock(clock), .reset(reset), .cpu_req(cpu_req), .cpu_op(cpu_op), .cpu_sfr(cpu_sfr),
		.cpu_addr(cpu_addr), .cpu_pc(cpu_pc), .cpu_wdata(cpu_wdata),
		.program_status_high_word(program_status_high_word), .boot_bit(boot_bit), .test_bit(test_bit),
		.firewall_hw_rights(firewall_hw_rights), .seg_wr(seg_wr), .seg_wr_index(seg_wr_index),
		.seg_wr_entry(seg_wr_entry), .mem_rdata(mem_rdata), .sfr_rdata(sfr_rdata), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .sfr_rd_en(sfr_rd_en),
		.sfr_wr_en(sfr_wr_en), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .cpu_done(cpu_done),
		.cpu_rdata(cpu_rdata), .cpu_violation(cpu_violation), .cpu_mode(cpu_mode));
	mbac_mem_model mem_u (.clock(clock), .mem_req(mem_req), .mem_addr(mem_addr), .sfr_rd_en(sfr_rd_en),
		.sfr_addr(sfr_addr), .mem_rdata(mem_rdata), .sfr_rdata(sfr_rdata));
	// 25 MHz clock
	initial begin
		forever #20 clock = ~clock;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [19:0] seen, input logic [19:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
			bad_count++;
		end
	endtask
	// Mode inputs, then the registered mode one edge later
	task automatic md(input logic b, t, input logic [7:0] p, input mbac_pkg::mbac_mode_e m);
		boot_bit = b;
		test_bit = t;
		program_status_high_word = p;
		@(posedge clock); #1;
		chk("mode", cpu_mode, m);
	endtask
	// One segment load pulse
	task automatic ld(input logic [5:0] i, input logic [2:0] r, input logic [1:0] h, input logic [19:0] f, l, o);
		seg_wr = 1;
		seg_wr_index = i;
		seg_wr_entry = '{r, h, f, l, o};
		@(posedge clock); #1;
		seg_wr = 0;
		// Idle edge so the next load raises its strobe in a later time step
		@(posedge clock);
		#1;
	endtask
	// One request; g says granted, pa is the physical or SFR address expected
	task automatic acc(input mbac_pkg::mbac_op_e op, input logic s, input logic [19:0] a, input logic g, input logic [19:0] pa);
		logic w;
		logic [7:0] d;
		w = (op == mbac_pkg::OP_WRITE);
		d = s ? (pa[7:0] ^ 8'ha5) : (pa[7:0] ^ 8'h5a);
		cpu_req = 1;
		cpu_op = op;
		cpu_sfr = s;
		cpu_addr = a;
		@(posedge clock); #1;
		cpu_req = 0;
		chk("strobe", {mem_req, mem_we, sfr_rd_en, sfr_wr_en}, g ? (s ? {2'b00, !w, w} : {1'b1, w, 2'b00}) : 0);
		if (g) chk("addr", s ? {12'h000, sfr_addr} : mem_addr, pa);
		if (g && w) chk("wdata", s ? sfr_wdata : mem_wdata, 8'hc3);
		@(posedge clock); #1;
		chk("answer", {cpu_done, cpu_violation, cpu_rdata}, {1'b1, !g, (g && !w) ? d : 8'h00});
	endtask
	task automatic t_boot();
		md(1, 0, 8'hc0, mbac_pkg::MODE_BOOT);
		acc(mbac_pkg::OP_EXEC, 0, 20'h00100, 1, 20'h00100);
		acc(mbac_pkg::OP_READ, 0, 20'h02000, 0, 0);
		acc(mbac_pkg::OP_WRITE, 0, 20'h40fff, 1, 20'h40fff);
		acc(mbac_pkg::OP_WRITE, 0, 20'h41000, 0, 0);
		acc(mbac_pkg::OP_READ, 0, 20'h801ff, 1, 20'h801ff);
		acc(mbac_pkg::OP_EXEC, 0, 20'h80000, 0, 0);
	endtask
	task automatic t_test();
		md(1, 1, 8'h80, mbac_pkg::MODE_TEST);
		acc(mbac_pkg::OP_READ, 0, 20'h02000, 1, 20'h02000);
		acc(mbac_pkg::OP_WRITE, 0, 20'h00010, 0, 0);
		acc(mbac_pkg::OP_WRITE, 0, 20'h53fff, 1, 20'h53fff);
		acc(mbac_pkg::OP_READ, 0, 20'h817ff, 1, 20'h817ff);
		acc(mbac_pkg::OP_READ, 0, 20'h81800, 0, 0);
		acc(mbac_pkg::OP_READ, 1, 20'h000b0, 1, 20'h000b0);
	endtask
	task automatic t_clos();
		md(0, 0, 8'hc0, mbac_pkg::MODE_CLOS);
		acc(mbac_pkg::OP_EXEC, 0, 20'h01fff, 1, 20'h01fff);
		acc(mbac_pkg::OP_WRITE, 0, 20'h40000, 1, 20'h40000);
		acc(mbac_pkg::OP_READ, 0, 20'h80200, 0, 0);
		acc(mbac_pkg::OP_EXEC, 0, 20'h41000, 0, 0);
		firewall_hw_rights = 2'b10;
		acc(mbac_pkg::OP_WRITE, 1, 20'h000c0, 1, 20'h000c0);
		acc(mbac_pkg::OP_READ, 1, 20'h000c0, 0, 0);
	endtask
	task automatic t_sys();
		md(0, 0, 8'h80, mbac_pkg::MODE_SYS);
		// Read and exec, hardware read; a disabled twin; read and write into app RAM
		ld(0, 3'b101, 2'b01, 20'h10000, 20'h100ff, 20'h00100);
		ld(1, 3'b000, 2'b11, 20'h20000, 20'h200ff, 20'h00000);
		ld(2, 3'b011, 2'b00, 20'h30000, 20'h300ff, 20'h50200);
		acc(mbac_pkg::OP_EXEC, 0, 20'h3ffff, 1, 20'h3ffff);
		acc(mbac_pkg::OP_READ, 0, 20'h01fff, 0, 0);
		acc(mbac_pkg::OP_WRITE, 0, 20'h40fff, 0, 0);
		acc(mbac_pkg::OP_EXEC, 0, 20'h41000, 1, 20'h41000);
		acc(mbac_pkg::OP_WRITE, 0, 20'h80200, 1, 20'h80200);
		acc(mbac_pkg::OP_WRITE, 1, 20'h00098, 1, 20'h00098);
	endtask
	task automatic t_user();
		md(0, 0, 8'h00, mbac_pkg::MODE_USER);
		// Loads from user code must be ignored
		ld(3, 3'b111, 2'b11, 20'h60000, 20'h600ff, 20'h00000);
		acc(mbac_pkg::OP_READ, 0, 20'h10000, 1, 20'h10100);
		acc(mbac_pkg::OP_EXEC, 0, 20'h100ff, 1, 20'h101ff);
		acc(mbac_pkg::OP_READ, 0, 20'h10100, 0, 0);
		acc(mbac_pkg::OP_WRITE, 0, 20'h10000, 0, 0);
		acc(mbac_pkg::OP_READ, 0, 20'h20010, 0, 0);
		acc(mbac_pkg::OP_WRITE, 0, 20'h30005, 1, 20'h80205);
		acc(mbac_pkg::OP_EXEC, 0, 20'h30005, 0, 0);
		acc(mbac_pkg::OP_READ, 0, 20'h60000, 0, 0);
	endtask
	task automatic t_sfr();
		cpu_pc = 20'h10000;
		acc(mbac_pkg::OP_READ, 1, 20'h00010, 1, 20'h00010);
		acc(mbac_pkg::OP_READ, 1, 20'h000b0, 0, 0);
		acc(mbac_pkg::OP_WRITE, 1, 20'h00098, 0, 0);
		acc(mbac_pkg::OP_READ, 1, 20'h00098, 1, 20'h00098);
		acc(mbac_pkg::OP_READ, 1, 20'h000c0, 1, 20'h000c0);
		acc(mbac_pkg::OP_WRITE, 1, 20'h000c0, 0, 0);
		cpu_pc = 20'h40000;
		acc(mbac_pkg::OP_READ, 1, 20'h000c0, 0, 0);
	endtask
	// Mid-run reset must empty the table and fall back to boot
	task automatic t_reset();
		reset = 1;
		repeat (2) @(posedge clock);
		#1;
		reset = 0;
		chk("reset2", {mem_req, sfr_rd_en, sfr_wr_en, cpu_done, cpu_mode}, {4'h0, mbac_pkg::MODE_BOOT});
		md(0, 0, 8'h00, mbac_pkg::MODE_USER);
		acc(mbac_pkg::OP_READ, 0, 20'h10000, 0, 0);
	endtask
	// Hang guard
	initial begin
		repeat (5000) @(posedge clock);
		bad_count++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge clock);
		#1;
		reset = 0;
		chk("reset", {mem_req, sfr_rd_en, sfr_wr_en, cpu_done, cpu_mode}, {4'h0, mbac_pkg::MODE_BOOT});
		t_boot();
		t_test();
		t_clos();
		t_sys();
		t_user();
		t_sfr();
		t_reset();
		summarize();
	end
endmodule
